// [testbench/sdm_debug_ctl_monitor.sv]
// Purpose: port-level checker for the debug mode controller
// Assumes: single clock domain, reset rst_n asynchronous active low
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
module sdm_debug_mon (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // pin drive
  input wire debug_pin_o,
  input wire debug_pin_oe,
  // core control
  input wire halted_mode,
  input wire wake_pulse,
  input wire step_pulse,
  input wire force_reset_req,
  input wire osc_keep_on,
  input wire watchdog_disable,
  input wire bkpt_hit,
  input wire mem_rd,
  input wire mem_wr
);
  // ==================================================
  // low drive length, saturating so a stuck pin cannot wrap
  logic [7:0] low_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 8'h00;
    else if (debug_pin_oe && !debug_pin_o) low_cnt <= (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
    else low_cnt <= 8'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // assertions
  a_low_then_speedup: assert property (debug_pin_oe && debug_pin_o && low_cnt != 8'h00
    |-> low_cnt == 8'h0d || low_cnt == 8'h80) else $error("low drive length wrong");
  a_speedup_one_cycle: assert property (debug_pin_oe && debug_pin_o |=> !debug_pin_oe)
    else $error("speedup pulse too long");
  a_wdog_while_halted: assert property (halted_mode |=> watchdog_disable)
    else $error("watchdog not held off while halted");
  a_wdog_in_user: assert property (!halted_mode |=> !watchdog_disable)
    else $error("watchdog held off in user mode");
  a_step_needs_halt: assert property ($rose(step_pulse) |-> $past(halted_mode))
    else $error("step issued while running");
  a_wake_halts_core: assert property (wake_pulse |-> ##[0:1] halted_mode ##1 !wake_pulse)
    else $error("background entry did not halt");
  a_bkpt_halts_core: assert property (bkpt_hit |-> ##[0:1] halted_mode ##1 !bkpt_hit)
    else $error("breakpoint hit did not halt");
  a_osc_when_halted: assert property ($rose(halted_mode) |=> osc_keep_on)
    else $error("oscillator not kept on");
  a_force_req_holds: assert property (force_reset_req |=> force_reset_req)
    else $error("force reset request dropped");
  a_mem_strobe_single: assert property (mem_rd |-> !mem_wr ##1 !mem_rd)
    else $error("memory strobe malformed");
  // ==================================================
  // main scenarios
  c_zero_bit: cover property (debug_pin_oe && debug_pin_o && low_cnt == 8'h0d);
  c_sync_pulse: cover property (debug_pin_oe && debug_pin_o && low_cnt == 8'h80);
  c_bkpt: cover property (bkpt_hit);
endmodule // sdm_debug_mon

bind sdm_debug_ctl sdm_debug_mon u_mon (
  .clk(clk), .rst_n(rst_n), .debug_pin_o(debug_pin_o), .debug_pin_oe(debug_pin_oe),
  .halted_mode(halted_mode), .wake_pulse(wake_pulse), .step_pulse(step_pulse),
  .force_reset_req(force_reset_req), .osc_keep_on(osc_keep_on),
  .watchdog_disable(watchdog_disable), .bkpt_hit(bkpt_hit), .mem_rd(mem_rd), .mem_wr(mem_wr)
);

// [testbench/sdm_pod_model.sv]
// Purpose: behavioural debug pod on the single-wire pin
// Assumes: tasks are entered just after a rising clock edge
// Notes: 20-clock bit slots keep falling edges well over 16 clocks apart
`timescale 1ns/1ns
module sdm_pod_model (
  // clock
  input wire clk,
  // pin level and pod pull-down
  input wire pin,
  output logic pull_low
);
  initial pull_low = 1'b0;
  // ==================================================
  // bit slots, each opened by a falling edge
  task automatic tx_bit(input logic b);
    pull_low <= 1'b1;
    repeat (b ? 4 : 17) @(posedge clk);
    pull_low <= 1'b0;
    repeat (b ? 16 : 3) @(posedge clk);
  endtask
  task automatic rx_bit(output logic b);
    pull_low <= 1'b1;
    repeat (2) @(posedge clk);
    pull_low <= 1'b0;
    repeat (10) @(posedge clk);
    b = pin;
    repeat (8) @(posedge clk);
  endtask
  task automatic tx8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tx_bit(v[i]);
  endtask
  task automatic tx16(input logic [15:0] v);
    tx8(v[15:8]);
    tx8(v[7:0]);
  endtask
  task automatic rx8(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) rx_bit(v[i]);
  endtask
  // long low asks for the timed reply; count how long the target holds the pin low
  task automatic sync(output logic [15:0] len);
    len = 16'h0000;
    pull_low <= 1'b1;
    repeat (140) @(posedge clk);
    pull_low <= 1'b0;
    repeat (400) begin
      @(posedge clk);
      if (pin === 1'b0) len = len + 16'h0001;
    end
  endtask
endmodule // sdm_pod_model

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the debug mode controller
// Assumes: pod model on the pin, pull-up when nobody drives
// Notes: reset cases come from a table, link cases are hand-written
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, cause_por, cause_force, fetch_valid, pull_low;
  logic [15:0] fetch_addr, mem_addr, last_a, len;
  logic [7:0] mem_wdata, mem_rdata, acc_wdata, v, last_d;
  logic dut_o, dut_oe, halted_mode, wake_pulse, step_pulse, force_reset_req;
  logic osc_keep_on, watchdog_disable, bkpt_hit, mem_rd, mem_wr, acc_wr;
  wire pin = dut_oe ? dut_o : !pull_low;
  int n_errors = 0, n_checks = 0, cyc = 0;
  logic [15:0] wr_cnt = 0, step_cnt = 0, wake_cnt = 0, bkpt_cnt = 0, acc_cnt = 0;
  logic [7:0] acc_val = 8'h00;
  // rows: {por, force, pin held low, expected halted}
  logic [3:0] rows [5] = '{4'b1011, 4'b1000, 4'b0111, 4'b0010, 4'b0000};
  sdm_debug_ctl u_dut (.clk(clk), .rst_n(rst_n), .cause_por(cause_por),
    .cause_force(cause_force), .debug_pin_i(pin), .debug_pin_o(dut_o), .debug_pin_oe(dut_oe),
    .halted_mode(halted_mode), .wake_pulse(wake_pulse), .step_pulse(step_pulse),
    .force_reset_req(force_reset_req), .osc_keep_on(osc_keep_on),
    .watchdog_disable(watchdog_disable), .bkpt_hit(bkpt_hit), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata), .acc_rdata(acc_val), .acc_wdata(acc_wdata),
    .acc_wr(acc_wr));
  sdm_pod_model u_pod (.clk(clk), .pin(pin), .pull_low(pull_low));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ==================================================
  // memory model and event log
  always @(posedge clk) begin
    mem_rdata <= mem_addr[7:0] ^ 8'h3c;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      report_and_stop();
    end
    if (mem_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 16'h0001;
      last_a <= mem_addr;
      last_d <= mem_wdata;
    end
    if (step_pulse === 1'b1) step_cnt <= step_cnt + 16'h0001;
    if (wake_pulse === 1'b1) wake_cnt <= wake_cnt + 16'h0001;
    if (bkpt_hit === 1'b1) bkpt_cnt <= bkpt_cnt + 16'h0001;
    // accumulator model: a write is read back by the next accumulator read
    if (acc_wr === 1'b1) begin
      acc_cnt <= acc_cnt + 16'h0001;
      acc_val <= acc_wdata;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // pin low must still be seen when the mode is decided, four edges after release
  task automatic do_reset(input logic por, input logic frc, input logic low);
    rst_n <= 1'b0;
    cause_por <= por;
    cause_force <= frc;
    u_pod.pull_low <= low;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    u_pod.pull_low <= 1'b0;
    repeat (600) @(posedge clk);
  endtask
  task automatic cmd_wait(input logic [7:0] c);
    u_pod.tx8(c);
    repeat (20) @(posedge clk);
  endtask
  initial begin
    rst_n = 1'b0;
    cause_por = 1'b0;
    cause_force = 1'b0;
    fetch_valid = 1'b0;
    fetch_addr = 16'h0000;
    @(posedge clk);
    foreach (rows[i]) begin
      do_reset(rows[i][3], rows[i][2], rows[i][1]);
      check(halted_mode, rows[i][0]);
      check(watchdog_disable, rows[i][0]);
      $display("reset case %0d done", i);
    end
    cmd_wait(8'h90);
    check(halted_mode, 1'b0);
    check(wake_cnt, 16'h0000);
    do_reset(1'b1, 1'b0, 1'b1);
    u_pod.tx8(8'he4);
    u_pod.rx8(v);
    check(v, 8'hc0);
    u_pod.tx8(8'hc0);
    u_pod.tx16(16'h1234);
    cmd_wait(8'h5a);
    check(wr_cnt, 16'h0001);
    check(last_a, 16'h1234);
    check(last_d, 8'h5a);
    u_pod.tx8(8'he0);
    u_pod.tx16(16'h0042);
    repeat (20) @(posedge clk);
    u_pod.rx8(v);
    check(v, 8'h7e);
    u_pod.tx8(8'h48);
    cmd_wait(8'h3c);
    check(acc_cnt, 16'h0001);
    u_pod.tx8(8'h68);
    u_pod.rx8(v);
    check(v, 8'h3c);
    cmd_wait(8'h10);
    check(step_cnt, 16'h0001);
    cmd_wait(8'h08);
    check(halted_mode, 1'b0);
    check(watchdog_disable, 1'b0);
    cmd_wait(8'h48);
    cmd_wait(8'h68);
    check(acc_cnt, 16'h0001);
    cmd_wait(8'h10);
    check(step_cnt, 16'h0001);
    u_pod.tx8(8'he4);
    u_pod.rx8(v);
    check(v, 8'h80);
    $display("memory and mode commands done");
    u_pod.tx8(8'hc2);
    u_pod.tx16(16'h0305);
    u_pod.tx8(8'he2);
    u_pod.rx8(v);
    check(v, 8'h03);
    u_pod.rx8(v);
    check(v, 8'h05);
    u_pod.tx8(8'hc4);
    cmd_wait(8'ha0);
    for (int i = 0; i < 16; i++) begin
      fetch_valid <= 1'b1;
      fetch_addr <= 16'h02f8 + 16'(i);
      @(posedge clk);
    end
    fetch_valid <= 1'b0;
    repeat (4) @(posedge clk);
    check(bkpt_cnt, 16'h0001);
    check(halted_mode, 1'b1);
    u_pod.tx8(8'h08);
    cmd_wait(8'h90);
    check(halted_mode, 1'b1);
    check(wake_cnt, 16'h0001);
    check(osc_keep_on, 1'b1);
    $display("breakpoint and wake done");
    u_pod.tx8(8'hc0);
    u_pod.tx16(16'h0055);
    for (int i = 0; i < 4; i++) u_pod.tx_bit(1'b0);
    repeat (600) @(posedge clk);
    check(wr_cnt, 16'h0001);
    u_pod.tx8(8'he4);
    u_pod.rx8(v);
    check(v, 8'hf0);
    u_pod.sync(len);
    check(len, 16'h0080);
    cmd_wait(8'h18);
    check(force_reset_req, 1'b1);
    $display("timeout, sync and force reset done");
    report_and_stop();
  end
endmodule // tb_top

// [verilog/sdm_debug_ctl.v]
// Purpose: mode selection and serial command engine of a single-wire debug controller
// Assumes: clk is the debug clock (10 MHz); the debug pin is pseudo open drain with pull-up
// Notes: pin split into input, output and output enable; reset cause flags come from
//        the system reset logic and stay valid across the release of rst_n
`timescale 1ns/1ns
`include "sdm_debug_regs.vh"

module sdm_debug_ctl #(
  parameter ADDR_W = 16
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // reset cause, held by the system reset logic
  input wire cause_por,
  input wire cause_force,
  // debug pin
  input wire debug_pin_i,
  output reg debug_pin_o,
  output reg debug_pin_oe,
  // core control
  output reg halted_mode,
  output reg wake_pulse,
  output reg step_pulse,
  output reg force_reset_req,
  output reg osc_keep_on,
  output reg watchdog_disable,
  output reg bkpt_hit,
  // instruction fetch watch
  input wire fetch_valid,
  input wire [ADDR_W-1:0] fetch_addr,
  // memory access
  output reg [ADDR_W-1:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_rd,
  output reg mem_wr,
  input wire [7:0] mem_rdata,
  // accumulator access
  input wire [7:0] acc_rdata,
  output reg [7:0] acc_wdata,
  output reg acc_wr
);

  localparam [2:0] PH_IDLE = 3'd0;
  localparam [2:0] PH_RX = 3'd1;
  localparam [2:0] PH_DLY = 3'd2;
  localparam [2:0] PH_TX = 3'd3;
  localparam [2:0] PH_SYNC = 3'd4;

  // ==================================================
  // pin synchroniser and filtered level
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg lvl_q;
  wire fall = lvl_q & ~sync2_q & ~sync3_q;
  wire rise = ~lvl_q & sync2_q & sync3_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      sync1_q <= debug_pin_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        lvl_q <= sync2_q;
      end
    end
  end

  // ==================================================
  // engine state
  reg [2:0] phase_q;
  reg [1:0] stage_q;
  reg [7:0] cmd_q;
  reg [15:0] shift_q;
  reg [4:0] left_q;
  reg bit_on_q;
  reg [4:0] bcnt_q;
  reg [9:0] gap_q;
  reg [7:0] low_q;
  reg [7:0] scnt_q;
  reg [4:0] dly_q;
  reg dly_tx_q;
  reg en_q;
  reg bkpt_en_q;
  reg bkpt_seen_q;
  reg [ADDR_W-1:0] bkpt_q;
  reg [1:0] init_q;
  reg init_done_q;
  wire [15:0] nv = {shift_q[14:0], lvl_q};

  wire [7:0] status = {en_q, halted_mode, bkpt_en_q, bkpt_seen_q, 4'h0};
  // the pin held low across reset is not a bit start
  wire edge_ok = fall & ~debug_pin_oe & (phase_q != PH_SYNC) & init_done_q;
  wire bkpt_match = en_q & bkpt_en_q & ~halted_mode & fetch_valid & (fetch_addr == bkpt_q);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_IDLE;
      stage_q <= 2'd0;
      cmd_q <= 8'h00;
      shift_q <= 16'h0000;
      left_q <= 5'd0;
      bit_on_q <= 1'b0;
      bcnt_q <= 5'd0;
      gap_q <= 10'd0;
      low_q <= 8'h00;
      scnt_q <= 8'h00;
      dly_q <= 5'd0;
      dly_tx_q <= 1'b0;
      en_q <= 1'b0;
      bkpt_en_q <= 1'b0;
      bkpt_seen_q <= 1'b0;
      bkpt_q <= {ADDR_W{1'b0}};
      init_q <= 2'd0;
      init_done_q <= 1'b0;
      debug_pin_o <= 1'b0;
      debug_pin_oe <= 1'b0;
      halted_mode <= 1'b0;
      wake_pulse <= 1'b0;
      step_pulse <= 1'b0;
      force_reset_req <= 1'b0;
      osc_keep_on <= 1'b0;
      watchdog_disable <= 1'b0;
      bkpt_hit <= 1'b0;
      mem_addr <= {ADDR_W{1'b0}};
      mem_wdata <= 8'h00;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      acc_wdata <= 8'h00;
      acc_wr <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      step_pulse <= 1'b0;
      bkpt_hit <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      acc_wr <= 1'b0;
      osc_keep_on <= en_q;
      watchdog_disable <= halted_mode;

      // ==================================================
      // mode choice once the synchroniser has settled after release
      if (!init_done_q) begin
        if (init_q == `SDM_INIT_WAIT) begin
          init_done_q <= 1'b1;
          // pin and error resets never look at the pin; an open pin reads high
          // lvl_q only takes the agreed level on this edge, so read the agreeing flops
          if ((cause_por | cause_force) & ~sync2_q & ~sync3_q) begin
            halted_mode <= 1'b1;
            en_q <= 1'b1;
          end
        end else begin
          init_q <= init_q + 2'd1;
        end
      end

      // single breakpoint comparator
      if (bkpt_match) begin
        halted_mode <= 1'b1;
        bkpt_hit <= 1'b1;
        bkpt_seen_q <= 1'b1;
      end

      // ==================================================
      // falling-edge gap timer and long-low sync request
      if (edge_ok) begin
        gap_q <= 10'd0;
      end else if (gap_q != `SDM_TIMEOUT - 10'd1) begin
        gap_q <= gap_q + 10'd1;
      end
      if (lvl_q & ~debug_pin_oe | (phase_q == PH_SYNC)) begin
        low_q <= 8'h00;
      end else if (~lvl_q & (low_q != `SDM_SYNC_REQ)) begin
        low_q <= low_q + 8'h01;
      end

      if (rise & (low_q == `SDM_SYNC_REQ) & (phase_q != PH_SYNC)) begin
        // a sync request overrides whatever command was under way
        phase_q <= PH_SYNC;
        scnt_q <= 8'h00;
        bit_on_q <= 1'b0;
        debug_pin_oe <= 1'b0;
      end else if ((phase_q != PH_IDLE) & (phase_q != PH_SYNC) & (phase_q != PH_DLY)
                   & (gap_q == `SDM_TIMEOUT - 10'd1)) begin
        // writes only happen on the last bit, so an abort leaves no trace
        phase_q <= PH_IDLE;
        bit_on_q <= 1'b0;
        debug_pin_oe <= 1'b0;
      end else if (phase_q == PH_SYNC) begin
        scnt_q <= scnt_q + 8'h01;
        if (scnt_q == `SDM_SYNC_GAP) begin
          debug_pin_oe <= 1'b1;
          debug_pin_o <= 1'b0;
        end else if (scnt_q == `SDM_SYNC_GAP + `SDM_SYNC_LOW) begin
          debug_pin_o <= 1'b1;
        end else if (scnt_q == `SDM_SYNC_GAP + `SDM_SYNC_LOW + 8'h01) begin
          debug_pin_oe <= 1'b0;
          phase_q <= PH_IDLE;
        end
      end else if (phase_q == PH_DLY) begin
        dly_q <= dly_q + 5'd1;
        if (dly_q == `SDM_DLY_CYC - 5'd1) begin
          if (dly_tx_q) begin
            shift_q <= {mem_rdata, 8'h00};
            left_q <= 5'd8;
            phase_q <= PH_TX;
          end else begin
            phase_q <= PH_IDLE;
          end
        end
      end else begin
        // ==================================================
        // bit window opened by each pod falling edge
        if (edge_ok & ~bit_on_q) begin
          bit_on_q <= 1'b1;
          bcnt_q <= 5'd0;
          if (phase_q == PH_IDLE) begin
            phase_q <= PH_RX;
            stage_q <= 2'd0;
            left_q <= 5'd8;
          end
          if ((phase_q == PH_TX) & ~shift_q[15]) begin
            debug_pin_oe <= 1'b1;
            debug_pin_o <= 1'b0;
          end
        end else if (bit_on_q) begin
          bcnt_q <= bcnt_q + 5'd1;
          if (phase_q == PH_TX) begin
            if (shift_q[15]) begin
              if (bcnt_q == `SDM_TX_ONE_SPD - 5'd1) begin
                debug_pin_oe <= 1'b1;
                debug_pin_o <= 1'b1;
              end else if (bcnt_q == `SDM_TX_ONE_SPD) begin
                debug_pin_oe <= 1'b0;
              end
            end else begin
              if (bcnt_q == `SDM_TX_ZERO_LOW - 5'd1) begin
                debug_pin_o <= 1'b1;
              end else if (bcnt_q == `SDM_TX_ZERO_LOW) begin
                debug_pin_oe <= 1'b0;
              end
            end
            if (bcnt_q == `SDM_BIT_CYC - 5'd1) begin
              bit_on_q <= 1'b0;
              shift_q <= {shift_q[14:0], 1'b0};
              left_q <= left_q - 5'd1;
              if (left_q == 5'd1) begin
                phase_q <= PH_IDLE;
              end
            end
          end else if (bcnt_q == `SDM_RX_SAMPLE) begin
            bit_on_q <= 1'b0;
            shift_q <= {shift_q[14:0], lvl_q};
            left_q <= left_q - 5'd1;
            if (left_q == 5'd1) begin
              phase_q <= PH_IDLE;
              // ==================================================
              // command decode; the serial pin is the only way in
              if (stage_q == 2'd0) begin
                cmd_q <= nv[7:0];
                case (nv[7:0])
                  `SDM_CMD_BACKGROUND: begin
                    if (en_q) begin
                      halted_mode <= 1'b1;
                      wake_pulse <= 1'b1;
                    end
                  end
                  `SDM_CMD_GO: begin
                    if (halted_mode) begin
                      halted_mode <= 1'b0;
                    end
                  end
                  `SDM_CMD_STEP: begin
                    step_pulse <= halted_mode;
                  end
                  `SDM_CMD_READ_STATUS: begin
                    shift_q <= {status, 8'h00};
                    left_q <= 5'd8;
                    phase_q <= PH_TX;
                  end
                  `SDM_CMD_READ_BKPT: begin
                    shift_q <= bkpt_q[15:0];
                    left_q <= 5'd16;
                    phase_q <= PH_TX;
                  end
                  `SDM_CMD_WRITE_CONTROL: begin
                    left_q <= 5'd8;
                    stage_q <= 2'd1;
                    phase_q <= PH_RX;
                  end
                  `SDM_CMD_WRITE_BKPT, `SDM_CMD_READ_BYTE, `SDM_CMD_WRITE_BYTE: begin
                    left_q <= 5'd16;
                    stage_q <= 2'd1;
                    phase_q <= PH_RX;
                  end
                  `SDM_CMD_READ_ACC: begin
                    if (halted_mode) begin
                      shift_q <= {acc_rdata, 8'h00};
                      left_q <= 5'd8;
                      phase_q <= PH_TX;
                    end
                  end
                  `SDM_CMD_WRITE_ACC: begin
                    if (halted_mode) begin
                      left_q <= 5'd8;
                      stage_q <= 2'd1;
                      phase_q <= PH_RX;
                    end
                  end
                  `SDM_CMD_FORCE_RESET: begin
                    force_reset_req <= 1'b1;
                  end
                  default: begin
                    phase_q <= PH_IDLE;
                  end
                endcase
              end else if (stage_q == 2'd1) begin
                case (cmd_q)
                  `SDM_CMD_WRITE_CONTROL: begin
                    en_q <= nv[`SDM_SC_ENABLE];
                    bkpt_en_q <= nv[`SDM_SC_BKPT_EN];
                    // a hit in the same cycle wins over the clear
                    if (~nv[`SDM_SC_BKPT_SEEN] & ~bkpt_match) begin
                      bkpt_seen_q <= 1'b0;
                    end
                  end
                  `SDM_CMD_WRITE_BKPT: begin
                    bkpt_q <= nv[ADDR_W-1:0];
                  end
                  `SDM_CMD_READ_BYTE: begin
                    mem_addr <= nv[ADDR_W-1:0];
                    mem_rd <= 1'b1;
                    dly_q <= 5'd0;
                    dly_tx_q <= 1'b1;
                    phase_q <= PH_DLY;
                  end
                  `SDM_CMD_WRITE_BYTE: begin
                    mem_addr <= nv[ADDR_W-1:0];
                    left_q <= 5'd8;
                    stage_q <= 2'd2;
                    phase_q <= PH_RX;
                  end
                  `SDM_CMD_WRITE_ACC: begin
                    acc_wdata <= nv[7:0];
                    acc_wr <= 1'b1;
                  end
                  default: begin
                    phase_q <= PH_IDLE;
                  end
                endcase
              end else begin
                mem_wdata <= nv[7:0];
                mem_wr <= 1'b1;
                dly_q <= 5'd0;
                dly_tx_q <= 1'b0;
                phase_q <= PH_DLY;
              end
            end
          end
        end
      end
    end
  end

endmodule // sdm_debug_ctl

// [verilog/sdm_debug_regs.vh]
// Purpose: constants of the single-wire debug mode controller
// Assumes: counts are in debug clock cycles (the block clock)
// Notes: definitions only
`ifndef SDM_DEBUG_REGS_VH
`define SDM_DEBUG_REGS_VH

// ==================================================
// bit timing, in debug clock cycles
`define SDM_BIT_CYC 5'd16
`define SDM_RX_SAMPLE 5'd10
`define SDM_TX_ONE_SPD 5'd7
`define SDM_TX_ZERO_LOW 5'd13
`define SDM_DLY_CYC 5'd16
`define SDM_TIMEOUT 10'd512
`define SDM_SYNC_REQ 8'd128
`define SDM_SYNC_GAP 8'd16
`define SDM_SYNC_LOW 8'd128
`define SDM_INIT_WAIT 2'd3

// ==================================================
// command codes
`define SDM_CMD_BACKGROUND 8'h90
`define SDM_CMD_GO 8'h08
`define SDM_CMD_STEP 8'h10
`define SDM_CMD_READ_STATUS 8'he4
`define SDM_CMD_WRITE_CONTROL 8'hc4
`define SDM_CMD_READ_BKPT 8'he2
`define SDM_CMD_WRITE_BKPT 8'hc2
`define SDM_CMD_READ_BYTE 8'he0
`define SDM_CMD_WRITE_BYTE 8'hc0
`define SDM_CMD_READ_ACC 8'h68
`define SDM_CMD_WRITE_ACC 8'h48
`define SDM_CMD_FORCE_RESET 8'h18

// ==================================================
// status / control byte layout
`define SDM_SC_ENABLE 7
`define SDM_SC_HALTED 6
`define SDM_SC_BKPT_EN 5
`define SDM_SC_BKPT_SEEN 4

`endif
